// ### core/adc_backend.sv
// Digital back end of a 16-channel dual pipelined converter.
// Assumes stage decisions arrive synchronous to i_mclk; the sampling
// clock comes from outside and is synchronised here.
//
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
module adc_backend #(
  parameter int BIT_DIV = adc_backend_pkg::BIT_CYC // Cycles per bit
) (
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_nrst,
  // Sampling clock pin
  input  wire logic        i_sclk,
  // Stage decisions {hi,lo}, stage 0 in top bits
  input  wire logic [29:0] i_dec_a,
  input  wire logic [29:0] i_dec_b,
  // Register port
  input  wire logic [3:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [7:0]  o_rdata,
  // Sampling and selector controls
  output logic             o_hold,
  output logic      [2:0]  o_mux_sel,
  // Calibration drive to the analog stages
  output logic             o_cal_active,
  output logic      [3:0]  o_cal_stage,
  output logic             o_cal_thresh,
  output logic             o_cal_force,
  // Serial lanes
  output logic             o_oclk,
  output logic             o_frame,
  output logic      [7:0]  o_data,
  // Static settings
  output logic      [2:0]  o_drive,
  output logic             o_in_diff,
  output logic             o_in_bypass
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam int NS = adc_backend_pkg::STAGES;

  logic        sclk_m1, sclk_m2, sclk_m3;  // Pin synchroniser
  logic [7:0]  div_reg;                    // Bit divider
  logic [1:0]  bit_reg;                    // Bit within nibble
  logic        conv_reg;                   // Conversion tick seen
  logic [7:0]  ctrl_reg;                   // Mode settings
  logic [2:0]  caln_reg;                   // Stages to calibrate
  logic [2:0]  drive_reg;                  // Drive code
  logic        done_reg;                   // Calibration finished
  logic [15:0] res_a_reg, res_b_reg;       // Words for formatter
  logic [2:0]  ch_reg;                     // Channel of those words
  logic [15:0] sh_a_reg, sh_b_reg;         // Shifters
  logic        cal_wait_reg;               // Settle one tick
  logic [15:0] r1_a_reg, r1_b_reg;         // Forced-high results
  logic signed [15:0] w_hi_reg [2][NS];    // High weights
  logic signed [15:0] w_lo_reg [2][NS];    // Low weights
  adc_backend_pkg::cal_state_t state_reg, state_next;

  // ----------------------------------------------------------------
  // Weighted sum from a given stage down to the last
  // ----------------------------------------------------------------
  // Shared by conversion and calibration, so kept as one function.
  function automatic logic signed [15:0] wsum(
    input logic [29:0] dec, input int first, input int p);
    logic signed [15:0] acc;
    logic [1:0]         code;
    acc = 16'sh0000;
    for (int j = 0; j < NS; j++) begin
      code = dec[28-2*j +: 2];
      if (j >= first && code == 2'b11) begin
        acc = acc + w_hi_reg[p][j];
      end else if (j >= first && code == 2'b00) begin
        acc = acc + w_lo_reg[p][j];
      end
    end
    return acc;
  endfunction

  // Nibble msbs of both words onto the eight data lanes
  function automatic logic [7:0] lanes(input logic [15:0] a,
                                       input logic [15:0] b);
    return {a[15], a[11], a[7], a[3], b[15], b[11], b[7], b[3]};
  endfunction

  // ----------------------------------------------------------------
  // Timing: sampling edge, bit enable, conversion tick
  // ----------------------------------------------------------------
  wire sclk_rise = sclk_m2 & ~sclk_m3;
  wire bit_en    = (div_reg == 8'(BIT_DIV - 1));
  wire half_en   = (div_reg == 8'(BIT_DIV / 2 - 1));
  wire slot_end  = bit_en & (bit_reg == 2'h3);
  wire conv_tick = sclk_rise | slot_end;

  // external sampling clock synchronised
  // Two flops on the pin before the edge detector looks at it
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      sclk_m1 <= 1'b0;
      sclk_m2 <= 1'b0;
      sclk_m3 <= 1'b0;
    end else begin
      sclk_m1 <= i_sclk;
      sclk_m2 <= sclk_m1;
      sclk_m3 <= sclk_m2;
    end
  end

  // Divider restarts on each sampling edge to stay phase aligned
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      div_reg  <= 8'h00;
      bit_reg  <= 2'h0;
      conv_reg <= 1'b0;
    end else begin
      conv_reg <= conv_tick;
      if (sclk_rise || bit_en) begin
        div_reg <= 8'h00;
      end else begin
        div_reg <= div_reg + 8'h01;
      end
      if (sclk_rise) begin
        bit_reg <= 2'h0;
      end else if (bit_en) begin
        bit_reg <= bit_reg + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sample hold and channel selector
  // ----------------------------------------------------------------
  // Hold pulses on the sampling edge; selector steps at each slot end
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      o_hold    <= 1'b0;
      o_mux_sel <= 3'h0;
    end else begin
      o_hold <= sclk_rise;
      if (sclk_rise) begin
        o_mux_sel <= 3'h0;
      end else if (slot_end) begin
        o_mux_sel <= o_mux_sel + 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Conversion results
  // ----------------------------------------------------------------
  wire        dbg     = ctrl_reg[adc_backend_pkg::CTRL_DEBUG];
  wire [29:0] dbg_dec = ctrl_reg[adc_backend_pkg::CTRL_DBGSEL]
                        ? i_dec_b : i_dec_a;
  // raw decisions in top fifteen bits
  wire [15:0] word_a  = dbg ? {dbg_dec[29:15], 1'b0}
                            : wsum(i_dec_a, 0, 0) + adc_backend_pkg::MID;
  wire [15:0] word_b  = dbg ? {dbg_dec[14:0], 1'b0}
                            : wsum(i_dec_b, 0, 1) + adc_backend_pkg::MID;

  // Full 16 bits kept; the receiver assembles all sixteen
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      res_a_reg <= 16'h0000;
      res_b_reg <= 16'h0000;
      ch_reg    <= 3'h0;
    end else if (conv_tick) begin
      res_a_reg <= word_a;
      res_b_reg <= word_b;
      ch_reg    <= sclk_rise ? 3'h0 : o_mux_sel + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // Serial formatter
  // ----------------------------------------------------------------
  // Words are loaded one cycle after capture, costing one cycle of
  // latency but keeping the shifter off the adder path.
  wire [15:0] sh_a_next = conv_reg ? res_a_reg : sh_a_reg << 1;
  wire [15:0] sh_b_next = conv_reg ? res_b_reg : sh_b_reg << 1;
  wire        load_now  = conv_reg;

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      sh_a_reg <= 16'h0000;
      sh_b_reg <= 16'h0000;
      o_data   <= 8'h00;
      o_frame  <= 1'b0;
      o_oclk   <= 1'b0;
    end else if (load_now || (half_en && !conv_tick)) begin
      // Bits move in the low half of each bit period, so the
      // output clock rise lands mid-bit and all four bits are clocked
      // nibble msb first per lane
      sh_a_reg <= sh_a_next;
      sh_b_reg <= sh_b_next;
      o_data   <= lanes(sh_a_next, sh_b_next);
      o_frame  <= load_now && (ch_reg == 3'h0);
      o_oclk   <= 1'b0;
    end else if (bit_en) begin
      // clock lane beside frame and data
      o_oclk   <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  wire wr_ctrl  = i_wr && (i_addr == adc_backend_pkg::OFS_CTRL);
  wire wr_cal   = i_wr && (i_addr == adc_backend_pkg::OFS_CAL);
  wire wr_drive = i_wr && (i_addr == adc_backend_pkg::OFS_DRIVE);
  wire wr_stat  = i_wr && (i_addr == adc_backend_pkg::OFS_STATUS);
  wire cal_go   = wr_cal && i_wdata[adc_backend_pkg::CAL_START];
  wire busy     = !state_reg[0];
  wire cal_fin  = (state_reg == adc_backend_pkg::CS_NEG0) &&
                  conv_tick && cal_wait_reg && (o_cal_stage == 4'h0);
  wire [7:0] rd_mux =
    (i_addr == adc_backend_pkg::OFS_CTRL)   ? ctrl_reg :
    (i_addr == adc_backend_pkg::OFS_CAL)    ? {busy, 4'h0, caln_reg} :
    (i_addr == adc_backend_pkg::OFS_DRIVE)  ? {5'h00, drive_reg} :
    (i_addr == adc_backend_pkg::OFS_STATUS) ? {6'h00, done_reg, busy} :
                                              8'h00;

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      ctrl_reg  <= adc_backend_pkg::CTRL_RST;
      caln_reg  <= adc_backend_pkg::CALN_RST;
      drive_reg <= adc_backend_pkg::DRIVE_RST;
      done_reg  <= 1'b0;
      o_rdata   <= 8'h00;
    end else begin
      o_rdata <= i_rd ? rd_mux : 8'h00;
      if (wr_ctrl) ctrl_reg <= i_wdata;
      if (wr_cal && !busy) caln_reg <= i_wdata[2:0];
      if (wr_drive) drive_reg <= i_wdata[2:0];
      // Finish event wins over a write-one clear
      if (cal_fin) begin
        done_reg <= 1'b1;
      end else if (wr_stat && i_wdata[adc_backend_pkg::STAT_DONE]) begin
        done_reg <= 1'b0;
      end
    end
  end

  // Static settings straight to the analog side
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      o_drive     <= adc_backend_pkg::DRIVE_RST;
      o_in_diff   <= 1'b0;
      o_in_bypass <= 1'b0;
    end else begin
      o_drive     <= drive_reg;
      o_in_diff   <= ctrl_reg[adc_backend_pkg::CTRL_DIFF];
      o_in_bypass <= ctrl_reg[adc_backend_pkg::CTRL_BYPASS];
    end
  end

  // ----------------------------------------------------------------
  // Calibration sequencer
  // ----------------------------------------------------------------
  // Each forced state waits one tick to settle, then is captured.
  wire step = conv_tick && cal_wait_reg;
  // A start write may carry the count too, so use the new value then
  wire [2:0] caln_eff = (wr_cal && !busy) ? i_wdata[2:0] : caln_reg;
  wire [3:0] stage_first = {1'b0, caln_eff} - 4'h1;
  wire signed [15:0] lo_a = wsum(i_dec_a, int'(o_cal_stage) + 1, 0);
  wire signed [15:0] lo_b = wsum(i_dec_b, int'(o_cal_stage) + 1, 1);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      adc_backend_pkg::CS_IDLE: begin
        if (cal_go && caln_eff != 3'h0) begin
          state_next = adc_backend_pkg::CS_POS1;
        end
      end
      adc_backend_pkg::CS_POS1: if (step) begin
        state_next = adc_backend_pkg::CS_POS0;
      end
      adc_backend_pkg::CS_POS0: if (step) begin
        state_next = adc_backend_pkg::CS_NEG1;
      end
      adc_backend_pkg::CS_NEG1: if (step) begin
        state_next = adc_backend_pkg::CS_NEG0;
      end
      adc_backend_pkg::CS_NEG0: if (step) begin
        state_next = (o_cal_stage == 4'h0) ? adc_backend_pkg::CS_IDLE
                                           : adc_backend_pkg::CS_POS1;
      end
      default: state_next = adc_backend_pkg::CS_IDLE;
    endcase
  end

  // State, stage pointer and the drive presented to the stage
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      state_reg    <= adc_backend_pkg::CS_IDLE;
      cal_wait_reg <= 1'b0;
      o_cal_stage  <= 4'h0;
      o_cal_active <= 1'b0;
      o_cal_thresh <= 1'b0;
      o_cal_force  <= 1'b0;
    end else begin
      state_reg    <= state_next;
      cal_wait_reg <= (state_next != state_reg) ? 1'b0
                    : (conv_tick ? 1'b1 : cal_wait_reg);
      // start low, walk toward stage zero
      if (state_reg == adc_backend_pkg::CS_IDLE) begin
        o_cal_stage <= stage_first;
      end else if (step && state_reg == adc_backend_pkg::CS_NEG0) begin
        o_cal_stage <= o_cal_stage - 4'h1;
      end
      o_cal_active <= !state_next[0];
      o_cal_thresh <= state_next[1] | state_next[2];
      o_cal_force  <= state_next[1] | state_next[3];
    end
  end

  // Weight table: nominal halving weights until calibrated
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      r1_a_reg <= 16'h0000;
      r1_b_reg <= 16'h0000;
      for (int p = 0; p < 2; p++) begin
        for (int j = 0; j < NS; j++) begin
          w_hi_reg[p][j] <= adc_backend_pkg::W_NOM >> j;
          w_lo_reg[p][j] <= -(adc_backend_pkg::W_NOM >> j);
        end
      end
    end else if (step) begin
      if (state_reg[1] || state_reg[3]) begin
        r1_a_reg <= lo_a;
        r1_b_reg <= lo_b;
      end
      if (state_reg == adc_backend_pkg::CS_POS0) begin
        w_hi_reg[0][o_cal_stage] <= r1_a_reg - lo_a;
        w_hi_reg[1][o_cal_stage] <= r1_b_reg - lo_b;
      end
      if (state_reg == adc_backend_pkg::CS_NEG0) begin
        w_lo_reg[0][o_cal_stage] <= lo_a - r1_a_reg;
        w_lo_reg[1][o_cal_stage] <= lo_b - r1_b_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_forced_high;
    state_reg == adc_backend_pkg::CS_POS1 && step;
  endsequence
  sequence s_forced_low;
    o_cal_force == 1'b0 && o_cal_thresh == 1'b1;
  endsequence

  AST_TICK_ALIGN: assert property (@(posedge i_mclk)
    disable iff (!i_nrst) sclk_rise |=> conv_reg)
    else $error("tick not aligned to sampling edge");
  AST_HOLD: assert property (@(posedge i_mclk)
    disable iff (!i_nrst) sclk_rise |=> o_hold && o_mux_sel == 3'h0)
    else $error("hold or selector wrong after sampling edge");
  AST_MUX_STEP: assert property (@(posedge i_mclk)
    disable iff (!i_nrst) slot_end && !sclk_rise
    |=> o_mux_sel == $past(o_mux_sel) + 3'h1)
    else $error("selector did not step");
  AST_CAL_RANGE: assert property (@(posedge i_mclk)
    disable iff (!i_nrst) o_cal_active |-> o_cal_stage < 4'h7)
    else $error("calibrated stage beyond limit");
  AST_FORCE_ORDER: assert property (@(posedge i_mclk)
    disable iff (!i_nrst) s_forced_high |=> s_forced_low)
    else $error("forced low did not follow forced high");
  AST_CAL_START: assert property (@(posedge i_mclk)
    disable iff (!i_nrst) $rose(o_cal_active)
    |-> o_cal_stage == {1'b0, caln_reg} - 4'h1)
    else $error("calibration not begun at lowest stage");
  AST_DATA_FALL: assert property (@(posedge i_mclk)
    disable iff (!i_nrst) $changed(o_data) |-> !o_oclk)
    else $error("data moved while output clock high");
  AST_FRAME_ONE: assert property (@(posedge i_mclk)
    disable iff (!i_nrst) $rose(o_frame) |-> $past(ch_reg) == 3'h0)
    else $error("frame marker off channel zero");

endmodule

// ### core/adc_backend_pkg.sv
// Constants shared by the pipelined converter back end.
// Assumes one 125 MHz system clock; all slower rates are enables.
package adc_backend_pkg;

  // ----------------------------------------------------------------
  // Rates and derived cycle counts
  // ----------------------------------------------------------------
  localparam int MCLK_HZ = 125_000_000;  // System clock
  localparam int BIT_HZ  = 64_000_000;   // Serial bit rate
  // Least time per bit rounds up to whole cycles
  localparam int BIT_CYC = (MCLK_HZ + BIT_HZ - 1) / BIT_HZ;
  localparam int SLOT_BITS = 4;          // Bits per nibble slot
  localparam int CHANNELS  = 8;          // Channels per pipeline

  // ----------------------------------------------------------------
  // Converter shape
  // ----------------------------------------------------------------
  localparam int STAGES   = 15;          // Stages per pipeline
  localparam int RES_W    = 16;          // Result width
  localparam int CAL_MAX  = 7;           // Most stages calibrated
  localparam logic [15:0] W_NOM = 16'h4000; // Stage 0 nominal weight
  localparam logic [15:0] MID   = 16'h8000; // Mid-scale offset

  // ----------------------------------------------------------------
  // Register offsets (8-bit registers)
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_CTRL   = 4'h0;
  localparam logic [3:0] OFS_CAL    = 4'h1;
  localparam logic [3:0] OFS_DRIVE  = 4'h2;
  localparam logic [3:0] OFS_STATUS = 4'h3;

  // Field positions
  localparam int CTRL_DEBUG  = 0;        // Raw stage output mode
  localparam int CTRL_DBGSEL = 1;        // Pipeline shown in debug
  localparam int CTRL_DIFF   = 2;        // Differential inputs
  localparam int CTRL_BYPASS = 3;        // Input buffers bypassed
  localparam int CAL_START   = 7;        // Write 1 starts sequencer
  localparam int STAT_BUSY   = 0;
  localparam int STAT_DONE   = 1;

  // Reset values
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [2:0] CALN_RST  = 3'h0;
  localparam logic [2:0] DRIVE_RST = 3'h0;

  // Calibration sequencer states
  typedef enum logic [5:0] {
    CS_IDLE = 6'h01,
    CS_POS1 = 6'h02,
    CS_POS0 = 6'h04,
    CS_NEG1 = 6'h08,
    CS_NEG0 = 6'h10
  } cal_state_t;

endpackage

// ### sim/agg_sink.sv
// Behavioural model of the aggregator that latches the serial lanes.
// Assumes lanes and frame settle before each rise of the output clock.
`timescale 1ns/100ps
module agg_sink (
  // Clocks
  input  wire logic        i_mclk,
  input  wire logic        i_oclk,
  // Serial lanes
  input  wire logic        i_frame,
  input  wire logic [7:0]  i_data,
  // Edge watch enable
  input  wire logic        i_arm,
  // Assembled words and counts
  output logic      [15:0] o_word_a,
  output logic      [15:0] o_word_b,
  output int               o_frames,
  output int               o_bits,
  output int               o_late
);
  logic [3:0] sh [8];      // One shifter per lane
  logic [1:0] pos;         // Bit position within a slot
  logic [8:0] lane_prev;   // Frame and lanes one cycle ago
  logic       oclk_prev;   // Output clock one cycle ago

  // Counters start clear; this model never drives the block
  initial begin
    o_frames = 0;
    o_bits = 0;
    o_late = 0;
    pos = 2'h0;
  end

  always @(posedge i_oclk) begin
    for (int l = 0; l < 8; l++) sh[l] = {sh[l][2:0], i_data[l]};
    // Frame realigns the slot, so a lost bit skews words only until the next frame
    pos = i_frame ? 2'h0 : pos + 2'h1;
    o_bits++;
    if (i_frame) o_frames++;
    if (pos == 2'h3) begin
      o_word_a = {sh[7], sh[6], sh[5], sh[4]};
      o_word_b = {sh[3], sh[2], sh[1], sh[0]};
    end
  end

  // watch for lane moves off the falling edge
  always @(posedge i_mclk) begin
    if (i_arm && {i_frame, i_data} !== lane_prev && !(oclk_prev && !i_oclk))
      o_late++;
    lane_prev = {i_frame, i_data};
    oclk_prev = i_oclk;
  end
endmodule

// ### sim/test_pipeline_adc_digital_backend.sv
// Self-checking bench for the converter back end.
// Assumes the design package and the aggregator model compile first.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin samples_checked++; \
  if ((g) !== (e)) begin mismatches++; \
  $display("BAD %s exp %h got %h", nm, (e), (g)); end end
module test_pipeline_adc_digital_backend;
  // Design inputs, all set at time zero
  logic        i_mclk  = 1'b0;
  logic        i_nrst  = 1'b0;
  logic        i_sclk  = 1'b0;
  logic [29:0] i_dec_a = 30'h0;
  logic [29:0] i_dec_b = 30'h0;
  logic [3:0]  i_addr  = 4'h0;
  logic [7:0]  i_wdata = 8'h0;
  logic        i_wr    = 1'b0;
  logic        i_rd    = 1'b0;
  // Design outputs
  logic [7:0]  o_rdata, o_data;
  logic [3:0]  o_cal_stage;
  logic [2:0]  o_mux_sel, o_drive;
  logic        o_hold, o_cal_active, o_cal_thresh, o_cal_force;
  logic        o_oclk, o_frame, o_in_diff, o_in_bypass;
  // Aggregator view and bookkeeping
  logic [15:0] rx_a, rx_b;
  int          rx_frames, rx_bits, rx_late;
  logic        arm = 1'b0;
  int          half_ns = 40;   // Sampling half period, 40 ns at start
  int          mismatches = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  // ----
  // Clocks and instances
  // ----
  // main clock
  always #4 i_mclk = ~i_mclk;
  // sampling clock, kept clear of main edges
  initial begin
    #2;
    forever #(half_ns) i_sclk = ~i_sclk;
  end

  adc_backend #(.BIT_DIV(2)) dut_u (
    .i_mclk, .i_nrst, .i_sclk, .i_dec_a, .i_dec_b, .i_addr, .i_wdata,
    .i_wr, .i_rd, .o_rdata, .o_hold, .o_mux_sel, .o_cal_active,
    .o_cal_stage, .o_cal_thresh, .o_cal_force, .o_oclk, .o_frame,
    .o_data, .o_drive, .o_in_diff, .o_in_bypass);

  agg_sink sink_u (
    .i_mclk, .i_oclk(o_oclk), .i_frame(o_frame), .i_data(o_data),
    .i_arm(arm), .o_word_a(rx_a), .o_word_b(rx_b),
    .o_frames(rx_frames), .o_bits(rx_bits), .o_late(rx_late));

  // ----
  // Access tasks
  // ----
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic chk_rd(input string nm, input logic [3:0] a,
                        input logic [7:0] e);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1;
    `CHK(nm, e, o_rdata)
  endtask

  // Ten sampling periods of 64 cycles: counts are phase independent
  task automatic fmt(input string nm, input logic [15:0] ea,
                     input logic [15:0] eb);
    int f0;
    int b0;
    wait_cyc(192);
    f0 = rx_frames;
    b0 = rx_bits;
    wait_cyc(640);
    `CHK({nm, " frames"}, 10, rx_frames - f0)
    `CHK({nm, " bits"}, 320, rx_bits - b0)
    `CHK({nm, " word a"}, ea, rx_a)
    `CHK({nm, " word b"}, eb, rx_b)
    $display("test %s done", nm);
  endtask

  // Steps run stage count-1 down to 0, four forced states each
  task automatic cal(input int n);
    logic [5:0] q [$];
    logic [5:0] v;
    logic [5:0] e;
    int k;
    wr(4'h1, 8'h80 | 8'(n));
    wait_cyc(2);
    `CHK("cal start", n != 0, o_cal_active)
    if (n != 0) begin
      wr(4'h1, 8'h05);
      chk_rd("cal busy", 4'h1, 8'h80 | 8'(n));
    end
    for (k = 0; k < 2000 && o_cal_active === 1'b1; k++) begin
      v = {o_cal_stage, o_cal_thresh, o_cal_force};
      if (q.size() == 0 || q[$] !== v) q.push_back(v);
      wait_cyc(1);
    end
    `CHK("cal steps", 4 * n, q.size())
    for (k = 0; k < q.size(); k++) begin
      e = {4'(n - 1 - k / 4), ~k[1], ~k[0]};
      `CHK("cal step", e, q[k])
    end
    chk_rd("cal count", 4'h1, 8'(n));
    chk_rd("cal done", 4'h3, (n != 0) ? 8'h02 : 8'h00);
    wr(4'h3, 8'h02);
    chk_rd("done clear", 4'h3, 8'h00);
    $display("test calibrate %0d done", n);
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Hang guard, well above the few thousand cycles expected
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      $display("BAD timeout exp %h got %h", 0, cycles);
      test_done();
    end
  end

  // ----
  // Main sequence
  // ----
  initial begin
    int ns [3];
    ns = '{0, 1, 7};
    repeat (6) @(posedge i_mclk);
    i_nrst <= 1'b1;
    chk_rd("ctrl reset", 4'h0, 8'h00);
    chk_rd("cal reset", 4'h1, 8'h00);
    chk_rd("drive reset", 4'h2, 8'h00);
    chk_rd("status reset", 4'h3, 8'h00);
    wr(4'hf, 8'hff);
    chk_rd("unmapped", 4'hf, 8'h00);
    for (int c = 0; c < 8; c++) begin
      wr(4'h2, 8'(c));
      chk_rd("drive", 4'h2, 8'(c));
      `CHK("drive pin", 3'(c), o_drive)
    end
    for (int m = 0; m < 4; m++) begin
      wr(4'h0, 8'(m << 2));
      chk_rd("ctrl", 4'h0, 8'(m << 2));
      `CHK("input mode", 2'(m), {o_in_bypass, o_in_diff})
    end
    wr(4'h0, 8'h00);
    $display("test registers done");
    // Period of 64 cycles lets all eight slots finish
    @(posedge i_mclk);
    half_ns <= 256;
    i_dec_a <= {2'h3, 2'h2, {12{2'h1}}, 2'h3};
    i_dec_b <= {2'h0, 2'h3, {13{2'h1}}};
    wait_cyc(200);
    arm = 1'b1;
    fmt("normal", 16'hc001, 16'h6000);
    wr(4'h0, 8'h01);
    fmt("debug a", {i_dec_a[29:15], 1'b0}, {i_dec_a[14:0], 1'b0});
    wr(4'h0, 8'h03);
    fmt("debug b", {i_dec_b[29:15], 1'b0}, {i_dec_b[14:0], 1'b0});
    wr(4'h0, 8'h00);
    `CHK("late edges", 0, rx_late)
    for (int n = 0; n < 200 && o_hold !== 1'b1; n++) wait_cyc(1);
    for (int k = 0; k < 8; k++) begin
      `CHK("selector", 3'(k), o_mux_sel)
      wait_cyc(8);
    end
    `CHK("hold", 1'b1, o_hold)
    $display("test selector done");
    foreach (ns[i]) cal(ns[i]);
    test_done();
  end
endmodule
